// ===== src/acs_cfg.svh
// register offsets, field positions, reset values and timing counts of the action scheduler
// assumes inclusion by its bare name before any use
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_OFS_CTRL 12'h000
`define ACS_OFS_STATUS 12'h004
`define ACS_OFS_GKEY 12'h008
`define ACS_OFS_GMASK 12'h00c
`define ACS_OFS_DKEY 12'h010
`define ACS_OFS_SEL 12'h014
`define ACS_OFS_QDEPTH 12'h018
`define ACS_OFS_EVT 12'h01c
`define ACS_OFS_EVT_MASK 12'h020
`define ACS_OFS_NOTE_EN 12'h024
`define ACS_OFS_TIME_LO 12'h028
`define ACS_OFS_TIME_HI 12'h02c
`define ACS_OFS_OFFSET 12'h030
`define ACS_OFS_DELAY 12'h034
`define ACS_OFS_BEST 12'h038
`define ACS_OFS_LOCAL 12'h03c
`define ACS_OFS_LOCAL_MAC 12'h040
`define ACS_OFS_SYNC_TOL 12'h044
`define ACS_OFS_TIME_INC 12'h048
`define ACS_CTRL_PTP_EN 0
`define ACS_STAT_READY 0
`define ACS_STAT_SLAVE 1
`define ACS_EVT_LATE 0
`define ACS_EVT_EXP 1
`define ACS_EVT_DROP 2
`define ACS_EVT_SYNC 3
`define ACS_EVT_OVF 4
`define ACS_RST_ZERO32 32'h0000_0000
`define ACS_RST_ONE32 32'h0000_0001
`define ACS_RST_INC 32'h0000_0005
`define ACS_RST_TOL 32'h0000_0064
`define ACS_RST_ACC 8'hff
`define ACS_SYNC_PERIOD_NS 1000000
`define ACS_CLK_NS 5
`endif

// ===== src/acs_pkg.sv
// types shared by the action command scheduler
// assumes acs_cfg.svh for numbers
package acs_pkg;
   typedef struct packed {
      logic [31:0] device_key;
      logic [31:0] group_key;
      logic [31:0] group_mask;
      logic [31:0] action_index;
      logic has_time;
      logic [63:0] exec_time;
   } action_cmd_t;
   typedef struct packed {
      logic [7:0] accuracy;
      logic [47:0] mac;
   } clock_qual_t;
   typedef struct packed {
      logic [63:0] t1;
      logic [63:0] t2;
      logic [63:0] t3;
      logic [63:0] t4;
   } sync_stamps_t;
   typedef enum logic [1:0] {
      PTP_OFF,
      PTP_LISTEN,
      PTP_SLAVE,
      PTP_MASTER
   } ptp_state_t;
endpackage

// ===== src/action_command_scheduler.sv
// action command filter, timed scheduler and precision time slave with an ahb-lite register file
// assumes one clock hclk, async active-low reset, a mac that delivers decoded commands,
// announce qualities and end-to-end sync stamps as one-cycle strobes on hclk
//
// Notes on behaviour
// - act only when group keys match
// - require nonzero AND of 32-bit group masks
// - single action entry, index zero only
// - queue timed commands, report queue depth
// - hold programmable device key value
// - timed command exposes when local time reaches
// - untimed command exposes on receipt
// - ready for scheduled commands only once synchronized
// - time sync runs only while enabled
// - precision time protocol version 2 behaviour
// - best master election, best accuracy wins
// - accuracy tie broken by smallest mac
// - end-to-end stamps give path delay
// - slave corrects local clock by offset
// - periodic sync exchange corrects drift
// - notify selected event only when enabled
//
// The AHB-Lite slave port and the register offsets were decided locally.
`include "acs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module action_command_scheduler #(
   parameter int QUEUE_DEPTH = 4,
   parameter int SYNC_PERIOD_CYC = `ACS_SYNC_PERIOD_NS / `ACS_CLK_NS
) (
   // clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // received action command
   input wire logic cmd_valid,
   input wire acs_pkg::action_cmd_t cmd,
   // received announce from a peer clock
   input wire logic announce_valid,
   input wire acs_pkg::clock_qual_t announce,
   // end-to-end sync stamps, one exchange per strobe
   input wire logic stamps_valid,
   input wire acs_pkg::sync_stamps_t stamps,
   // outputs
   output logic exposure_start,
   output logic sync_request,
   output logic notify_valid,
   output logic [4:0] notify_events,
   output logic irq
);
   localparam int QW = $clog2(QUEUE_DEPTH + 1);
   localparam int PW = $clog2(SYNC_PERIOD_CYC + 1);

   typedef struct packed {
      logic ptp_en;
      logic [31:0] group_key;
      logic [31:0] group_mask;
      logic [31:0] device_key;
      logic [31:0] evt_mask;
      logic [31:0] note_en;
      logic [31:0] sync_tol;
      logic [31:0] time_inc;
      logic [7:0] local_acc;
      logic [47:0] local_mac;
      logic [4:0] evt;
      logic [63:0] now;
      logic [63:0] offset;
      logic [63:0] delay;
      acs_pkg::clock_qual_t best;
      acs_pkg::ptp_state_t ptp;
      logic synced;
      logic [PW-1:0] period_cnt;
      logic [QUEUE_DEPTH-1:0] qv;
      logic [QUEUE_DEPTH-1:0][63:0] qt;
      logic [QW-1:0] qdepth;
      logic ap_valid;
      logic ap_write;
      logic [11:0] ap_addr;
      logic [31:0] rdata;
      logic expose;
      logic sync_req;
      logic note_v;
      logic [4:0] note_e;
      logic irq;
   } state_t;

   state_t q, d;
   logic [4:0] evt_set;
   logic [QUEUE_DEPTH-1:0] fire;
   logic [QUEUE_DEPTH-1:0] free_oh;
   logic cmd_ok;
   logic [63:0] off_calc;
   logic [63:0] dly_calc;
   logic [63:0] abs_off;
   logic better;
   logic [QW-1:0] depth_cnt;

   // =====================================================
   // command filter
   always_comb begin
      cmd_ok = cmd_valid &&
               (cmd.device_key == q.device_key) &&
               (cmd.group_key == q.group_key) &&
               ((cmd.group_mask & q.group_mask) != `ACS_RST_ZERO32) &&
               (cmd.action_index == `ACS_RST_ZERO32);
   end

   // =====================================================
   // queue slots: fire and free search
   generate
      for (genvar i = 0; i < QUEUE_DEPTH; i++) begin : g_slot
         assign fire[i] = q.qv[i] && (q.now >= q.qt[i]);
         if (i == 0) begin : g_first
            assign free_oh[i] = !q.qv[i];
         end else begin : g_rest
            assign free_oh[i] = !q.qv[i] && (q.qv[i-1:0] == '1);
         end
      end
   endgenerate

   always_comb begin
      depth_cnt = '0;
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
         depth_cnt = depth_cnt + QW'(q.qv[i] && !fire[i]);
      end
   end

   // =====================================================
   // end-to-end offset and delay
   always_comb begin
      // delay = ((t2-t1)+(t4-t3))/2, offset = ((t2-t1)-(t4-t3))/2
      dly_calc = ((stamps.t2 - stamps.t1) + (stamps.t4 - stamps.t3)) >>> 1;
      off_calc = 64'($signed((stamps.t2 - stamps.t1) - (stamps.t4 - stamps.t3)) >>> 1);
      abs_off = off_calc[63] ? (~off_calc + 64'h0000_0000_0000_0001) : off_calc;
      better = (announce.accuracy < q.best.accuracy) ||
               ((announce.accuracy == q.best.accuracy) && (announce.mac < q.best.mac));
   end

   // =====================================================
   // next state
   always_comb begin
      d = q;
      evt_set = '0;
      d.expose = 1'b0;
      d.sync_req = 1'b0;
      d.note_v = 1'b0;
      d.note_e = '0;
      d.now = q.now + {32'h0000_0000, q.time_inc};
      // scheduled commands fire
      if (fire != '0) begin
         d.expose = 1'b1;
         evt_set[`ACS_EVT_EXP] = 1'b1;
      end
      d.qv = q.qv & ~fire;
      // accepted commands; failed ones leave everything untouched
      if (cmd_ok) begin
         if (!cmd.has_time) begin
            d.expose = 1'b1;
            evt_set[`ACS_EVT_EXP] = 1'b1;
         end else if (!q.synced) begin
            evt_set[`ACS_EVT_DROP] = 1'b1;
         end else if (cmd.exec_time <= q.now) begin
            d.expose = 1'b1;
            evt_set[`ACS_EVT_LATE] = 1'b1;
         end else if (free_oh == '0) begin
            evt_set[`ACS_EVT_OVF] = 1'b1;
         end else begin
            for (int i = 0; i < QUEUE_DEPTH; i++) begin
               if (free_oh[i]) begin
                  d.qv[i] = 1'b1;
                  d.qt[i] = cmd.exec_time;
               end
            end
         end
      end
      d.qdepth = depth_cnt + QW'((d.qv & ~(q.qv & ~fire)) != '0);
      // time protocol
      if (!q.ptp_en) begin
         d.ptp = acs_pkg::PTP_OFF;
         d.synced = 1'b0;
         d.period_cnt = '0;
      end else begin
         if (q.ptp == acs_pkg::PTP_OFF) begin
            d.ptp = acs_pkg::PTP_LISTEN;
            d.best = {q.local_acc, q.local_mac};
         end
         if (announce_valid && better) begin
            d.best = announce;
            d.ptp = acs_pkg::PTP_SLAVE;
            d.synced = 1'b0;
         end else if (q.best == {q.local_acc, q.local_mac} && q.ptp == acs_pkg::PTP_LISTEN) begin
            d.ptp = acs_pkg::PTP_MASTER;
            d.synced = 1'b1;
         end
         if (q.period_cnt == PW'(SYNC_PERIOD_CYC - 1)) begin
            d.period_cnt = '0;
            d.sync_req = (q.ptp == acs_pkg::PTP_SLAVE);
         end else begin
            d.period_cnt = q.period_cnt + PW'(1);
         end
         if (stamps_valid && q.ptp == acs_pkg::PTP_SLAVE) begin
            d.delay = dly_calc;
            d.offset = off_calc;
            d.now = q.now - off_calc + {32'h0000_0000, q.time_inc};
            if (abs_off <= {32'h0000_0000, q.sync_tol}) begin
               if (!q.synced) begin
                  evt_set[`ACS_EVT_SYNC] = 1'b1;
               end
               d.synced = 1'b1;
            end else begin
               d.synced = 1'b0;
            end
         end
      end
      // register bus data phase
      d.rdata = '0;
      if (q.ap_valid && q.ap_write) begin
         case (q.ap_addr)
            `ACS_OFS_CTRL: d.ptp_en = hwdata[`ACS_CTRL_PTP_EN];
            `ACS_OFS_GKEY: d.group_key = hwdata;
            `ACS_OFS_GMASK: d.group_mask = hwdata;
            `ACS_OFS_DKEY: d.device_key = hwdata;
            `ACS_OFS_EVT_MASK: d.evt_mask = hwdata;
            `ACS_OFS_NOTE_EN: d.note_en = hwdata;
            `ACS_OFS_SYNC_TOL: d.sync_tol = hwdata;
            `ACS_OFS_TIME_INC: d.time_inc = hwdata;
            `ACS_OFS_LOCAL: d.local_acc = hwdata[7:0];
            `ACS_OFS_LOCAL_MAC: d.local_mac[31:0] = hwdata;
            default: d.rdata = '0;
         endcase
      end
      // sticky events: set wins over write-one-clear
      if (q.ap_valid && q.ap_write && q.ap_addr == `ACS_OFS_EVT) begin
         d.evt = (q.evt & ~hwdata[4:0]) | evt_set;
      end else begin
         d.evt = q.evt | evt_set;
      end
      // notifications for enabled events only
      if ((evt_set & q.note_en[4:0]) != '0) begin
         d.note_v = 1'b1;
         d.note_e = evt_set & q.note_en[4:0];
      end
      d.irq = (d.evt & d.evt_mask[4:0]) != '0;
      // address phase capture and read data
      d.ap_valid = hsel && hready && htrans[1];
      d.ap_write = hwrite;
      d.ap_addr = haddr;
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr)
            `ACS_OFS_CTRL: d.rdata = {31'h0000_0000, q.ptp_en};
            `ACS_OFS_STATUS: d.rdata = {30'h0000_0000, q.ptp == acs_pkg::PTP_SLAVE, q.synced};
            `ACS_OFS_GKEY: d.rdata = q.group_key;
            `ACS_OFS_GMASK: d.rdata = q.group_mask;
            `ACS_OFS_DKEY: d.rdata = q.device_key;
            `ACS_OFS_SEL: d.rdata = `ACS_RST_ZERO32;
            `ACS_OFS_QDEPTH: d.rdata = 32'(q.qdepth);
            `ACS_OFS_EVT: d.rdata = {27'h000_0000, q.evt};
            `ACS_OFS_EVT_MASK: d.rdata = q.evt_mask;
            `ACS_OFS_NOTE_EN: d.rdata = q.note_en;
            `ACS_OFS_TIME_LO: d.rdata = q.now[31:0];
            `ACS_OFS_TIME_HI: d.rdata = q.now[63:32];
            `ACS_OFS_OFFSET: d.rdata = q.offset[31:0];
            `ACS_OFS_DELAY: d.rdata = q.delay[31:0];
            `ACS_OFS_BEST: d.rdata = {24'h00_0000, q.best.accuracy};
            `ACS_OFS_LOCAL: d.rdata = {24'h00_0000, q.local_acc};
            `ACS_OFS_LOCAL_MAC: d.rdata = q.local_mac[31:0];
            `ACS_OFS_SYNC_TOL: d.rdata = q.sync_tol;
            `ACS_OFS_TIME_INC: d.rdata = q.time_inc;
            default: d.rdata = '0;
         endcase
      end
   end

   // =====================================================
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.group_mask <= `ACS_RST_ZERO32;
         q.time_inc <= `ACS_RST_INC;
         q.sync_tol <= `ACS_RST_TOL;
         q.local_acc <= `ACS_RST_ACC;
         q.best <= '1;
         q.ptp <= acs_pkg::PTP_OFF;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // =====================================================
   // outputs
   always_comb begin
      hrdata = q.rdata;
      hreadyout = 1'b1;
      hresp = 1'b0;
      exposure_start = q.expose;
      sync_request = q.sync_req;
      notify_valid = q.note_v;
      notify_events = q.note_e;
      irq = q.irq;
   end
endmodule
`default_nettype wire

// ===== tb/acs_props.sv
// concurrent checks on the action command scheduler ports
// assumes bind onto action_command_scheduler, word writes on the bus
`timescale 1ns/1ps
`default_nettype none
module acs_props (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // register bus
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   // traffic
   input wire logic cmd_valid,
   input wire acs_pkg::action_cmd_t cmd,
   input wire logic exposure_start,
   input wire logic sync_request,
   input wire logic notify_valid,
   input wire logic [4:0] notify_events
);
   // ==========
   // shadow of written registers
   logic [31:0] shd_q [0:18];
   logic [4:0] wa_q;
   logic wr_q;
   logic tmd_q;
   logic ok_w;
   assign ok_w = cmd.device_key == shd_q[4] && cmd.group_key == shd_q[2]
      && (cmd.group_mask & shd_q[3]) != 32'h0000_0000 && cmd.action_index == 32'h0000_0000;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 5'h00;
         tmd_q <= 1'b0;
         for (int i = 0; i < 19; i++) shd_q[i] <= 32'h0000_0000;
      end else if (clk_en) begin
         wr_q <= hsel && hready && htrans[1] && hwrite && haddr[11:7] == 5'h00;
         wa_q <= haddr[6:2];
         if (wr_q && wa_q < 5'd19) shd_q[wa_q] <= hwdata;
         if (cmd_valid && cmd.has_time) tmd_q <= 1'b1;
      end
   end
   // ==========
   // assertions
   chk_key_miss: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && cmd_valid && !tmd_q && cmd.group_key != shd_q[2] |=> !exposure_start)
      else $error("exposure after wrong group key");
   chk_mask_miss: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && cmd_valid && !tmd_q && (cmd.group_mask & shd_q[3]) == 32'h0000_0000
      |=> !exposure_start) else $error("exposure after disjoint mask");
   chk_index_miss: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && cmd_valid && !tmd_q && cmd.action_index != 32'h0000_0000 |=> !exposure_start)
      else $error("exposure for nonzero index");
   chk_device_miss: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && cmd_valid && !tmd_q && cmd.device_key != shd_q[4] |=> !exposure_start)
      else $error("exposure after wrong device key");
   chk_untimed_go: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && cmd_valid && !cmd.has_time && ok_w |=> exposure_start)
      else $error("untimed command not exposed");
   chk_sync_gap: assert property (@(posedge hclk) disable iff (!hresetn)
      sync_request |=> !sync_request [*8]) else $error("sync requests too close");
   chk_ptp_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      sync_request |-> shd_q[0][0] || $past(shd_q[0][0]) || $past(shd_q[0][0], 2))
      else $error("sync request while disabled");
   chk_notify_sel: assert property (@(posedge hclk) disable iff (!hresetn)
      notify_valid |-> notify_events != 5'h00 && (notify_events & ~shd_q[9][4:0]) == 5'h00)
      else $error("notify for disabled event");
endmodule
bind action_command_scheduler acs_props chk (.hclk, .hresetn, .clk_en, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hwdata, .cmd_valid, .cmd, .exposure_start, .sync_request,
   .notify_valid, .notify_events);
`default_nettype wire

// ===== tb/action_command_scheduler_bench.sv
// self-checking bench of the action command scheduler
// assumes acs_props bound in, peer_model as the network master
`include "acs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module action_command_scheduler_bench;
   logic hclk, hresetn, hsel, hwrite, cmd_valid, hreadyout, hresp;
   logic exposure_start, sync_request, notify_valid, irq, announce_valid, stamps_valid;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, rd;
   logic [4:0] notify_events, note_q;
   logic [63:0] t;
   acs_pkg::action_cmd_t cmd;
   acs_pkg::clock_qual_t announce;
   acs_pkg::sync_stamps_t stamps;
   int mismatches, compares, exp_n, syn_n, n;
   action_command_scheduler #(.SYNC_PERIOD_CYC(50)) dut (.hclk, .hresetn, .clk_en(1'b1),
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .cmd_valid, .cmd, .announce_valid, .announce, .stamps_valid,
      .stamps, .exposure_start, .sync_request, .notify_valid, .notify_events, .irq);
   peer_model peer (.hclk, .hresetn, .sync_request, .announce_valid, .announce,
      .stamps_valid, .stamps);
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (exposure_start === 1'b1) exp_n++;
      if (sync_request === 1'b1) syn_n++;
      if (notify_valid === 1'b1) note_q = notify_events;
   end
   // ==========
   // helpers
   task chk(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] want);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rd, want);
   endtask
   task send(input acs_pkg::action_cmd_t c);
      cmd_valid <= 1'b1;
      cmd <= c;
      @(posedge hclk);
      cmd_valid <= 1'b0;
      cmd <= ~c;
      repeat (3) @(posedge hclk);
   endtask
   function automatic acs_pkg::action_cmd_t mk(logic [31:0] dk, logic [31:0] gk,
      logic [31:0] gm, logic [31:0] ix, logic ht, logic [63:0] et);
      mk = {dk, gk, gm, ix, ht, et};
   endfunction
   task close_out;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ==========
   // scenarios
   task t_filter;
      acs_pkg::action_cmd_t b [4];
      b[0] = mk(32'h0000_1234, 32'h0000_00a4, 32'h0000_0010, 32'h0000_0000, 1'b0, 64'h0);
      b[1] = mk(32'h0000_1234, 32'h0000_00a5, 32'h0000_000f, 32'h0000_0000, 1'b0, 64'h0);
      b[2] = mk(32'h0000_1234, 32'h0000_00a5, 32'h0000_0010, 32'h0000_0001, 1'b0, 64'h0);
      b[3] = mk(32'h0000_1235, 32'h0000_00a5, 32'h0000_0010, 32'h0000_0000, 1'b0, 64'h0);
      rdc(`ACS_OFS_STATUS, 32'h0000_0000);
      rdc(`ACS_OFS_QDEPTH, 32'h0000_0000);
      rdc(12'h0fc, 32'h0000_0000);
      chk(hresp, 1'b0);
      xfer(1'b1, `ACS_OFS_GKEY, 32'h0000_00a5);
      xfer(1'b1, `ACS_OFS_GMASK, 32'h0000_00f0);
      xfer(1'b1, `ACS_OFS_DKEY, 32'h0000_1234);
      xfer(1'b1, `ACS_OFS_EVT_MASK, 32'h0000_0002);
      xfer(1'b1, `ACS_OFS_NOTE_EN, 32'h0000_0002);
      n = exp_n;
      foreach (b[i]) send(b[i]);
      chk(exp_n, n);
      rdc(`ACS_OFS_EVT, 32'h0000_0000);
      send(mk(32'h0000_1234, 32'h0000_00a5, 32'h0000_0010, 32'h0000_0000, 1'b0, 64'h0));
      chk(exp_n, n + 1);
      chk(irq, 1'b1);
      chk(note_q, 5'h02);
      xfer(1'b1, `ACS_OFS_EVT, 32'h0000_0002);
      repeat (2) @(posedge hclk);
      chk(irq, 1'b0);
      send(mk(32'h0000_1234, 32'h0000_00a5, 32'h0000_0010, 32'h0000_0000, 1'b1, 64'h0));
      chk(exp_n, n + 1);
      rdc(`ACS_OFS_EVT, 32'h0000_0004);
      chk(irq, 1'b0);
      chk(syn_n, 0);
      $display("test filter done");
   endtask
   task t_ptp;
      int i;
      xfer(1'b1, `ACS_OFS_EVT, 32'h0000_0004);
      xfer(1'b1, `ACS_OFS_CTRL, 32'h0000_0001);
      for (i = 0; i < 40 && rd !== 32'h0000_0003; i++) xfer(1'b0, `ACS_OFS_STATUS, 32'h0);
      chk(rd, 32'h0000_0003);
      rdc(`ACS_OFS_DELAY, 32'h0000_0028);
      n = syn_n;
      repeat (250) @(posedge hclk);
      chk(syn_n - n > 3, 1'b1);
      xfer(1'b0, `ACS_OFS_TIME_LO, 32'h0);
      t[31:0] = rd;
      xfer(1'b0, `ACS_OFS_TIME_HI, 32'h0);
      t[63:32] = rd;
      n = exp_n;
      send(mk(32'h0000_1234, 32'h0000_00a5, 32'h0000_0010, 32'h0, 1'b1, t + 64'h3e8));
      rdc(`ACS_OFS_QDEPTH, 32'h0000_0001);
      for (i = 0; i < 400 && exp_n == n; i++) @(posedge hclk);
      chk(exp_n, n + 1);
      chk(i > 150, 1'b1);
      rdc(`ACS_OFS_QDEPTH, 32'h0000_0000);
      send(mk(32'h0000_1234, 32'h0000_00a5, 32'h0000_0010, 32'h0, 1'b1, 64'h0));
      chk(exp_n, n + 2);
      xfer(1'b0, `ACS_OFS_EVT, 32'h0);
      chk(rd[0], 1'b1);
      $display("test ptp done");
   endtask
   initial begin
      {hresetn, hsel, hwrite, cmd_valid, haddr, htrans, hwdata} = '0;
      cmd = '0;
      {mismatches, compares, exp_n, syn_n} = '0;
      note_q = 5'h00;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_filter;
      t_ptp;
      close_out;
   end
   initial begin
      #100000;
      mismatches++;
      close_out;
   end
endmodule
`default_nettype wire

// ===== tb/peer_model.sv
// peer master clock: periodic announces, stamps answering each sync request
// assumes hclk domain, stamps meaningful only while stamps_valid
`timescale 1ns/1ps
`default_nettype none
module peer_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // from the device
   input wire logic sync_request,
   // to the device
   output logic announce_valid,
   output acs_pkg::clock_qual_t announce,
   output logic stamps_valid,
   output acs_pkg::sync_stamps_t stamps
);
   // ==========
   // best clock, equal path both ways, delay 40
   localparam acs_pkg::clock_qual_t QUAL = {8'h00, 48'h0000_0000_0001};
   localparam acs_pkg::sync_stamps_t GOOD = {64'h0000_0000_0000_0000,
      64'h0000_0000_0000_0028, 64'h0000_0000_0000_0064, 64'h0000_0000_0000_008c};
   logic [3:0] tick_q;
   logic [1:0] wait_q;
   assign announce = announce_valid ? QUAL : ~QUAL;
   assign stamps = stamps_valid ? GOOD : ~GOOD;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_q <= 4'h0;
         wait_q <= 2'b00;
         announce_valid <= 1'b0;
         stamps_valid <= 1'b0;
      end else begin
         tick_q <= tick_q + 4'h1;
         announce_valid <= tick_q == 4'hf;
         wait_q <= {wait_q[0], sync_request};
         stamps_valid <= wait_q[1];
      end
   end
endmodule
`default_nettype wire
